// file: hw/iol_regs.vh
// Command selectors, field codes, reset values and timing counts for the I/O line unit
`ifndef IOL_REGS_VH
`define IOL_REGS_VH
// Command selectors on the host command port
`define IOL_SEL_FUNC_L0 5'h00
`define IOL_SEL_FUNC_L8 5'h08
`define IOL_SEL_FWD_EN 5'h09
`define IOL_SEL_SPT 5'h0A
`define IOL_SEL_FORCE 5'h0B
`define IOL_SEL_OUT_LEVEL 5'h0C
`define IOL_SEL_CHG_MASK 5'h0D
`define IOL_SEL_INTERVAL 5'h0E
`define IOL_SEL_ADC_REF 5'h0F
`define IOL_SEL_BOUND_ADDR 5'h10
`define IOL_SEL_TMO_L0 5'h11
`define IOL_SEL_TMO_L7 5'h18
`define IOL_SEL_PWM_PIN_0_FUNC 5'h19
`define IOL_SEL_PWM_PIN_1_FUNC 5'h1A
`define IOL_SEL_PWM_PIN_0_LEVEL 5'h1B
`define IOL_SEL_PWM_PIN_1_LEVEL 5'h1C
`define IOL_SEL_PWM_HOLD 5'h1D
`define IOL_SEL_RSSI_DUR 5'h1E
// Line function codes
`define IOL_FN_DISABLED 3'h0
`define IOL_FN_SPECIAL 3'h1
`define IOL_FN_ADC 3'h2
`define IOL_FN_DIN 3'h3
`define IOL_FN_OUT_LOW 3'h4
`define IOL_FN_OUT_HIGH 3'h5
// PWM pin function codes
`define IOL_PWM_OFF 2'h0
`define IOL_PWM_RSSI 2'h1
`define IOL_PWM_LEVEL 2'h2
// Reset values and the any-source bound address
`define IOL_RST_FUNC_L5 3'h1
`define IOL_RST_FUNC_L7 3'h1
`define IOL_RST_FWD_EN 1'h1
`define IOL_RST_SPT 8'h01
`define IOL_RST_BOUND_ADDR 64'hFFFFFFFFFFFFFFFF
`define IOL_ADDR_ANY 64'h000000000000FFFF
`define IOL_RST_TMO 8'hFF
`define IOL_RST_PWM_PIN_0_FUNC 2'h1
`define IOL_RST_PWM_PIN_1_FUNC 2'h0
`define IOL_RST_PWM_HOLD 8'hFF
`define IOL_RST_RSSI_DUR 8'h28
// Sample kinds on the sample stream
`define IOL_KIND_PERIODIC 2'h0
`define IOL_KIND_FORCED 2'h1
`define IOL_KIND_CHANGE 2'h2
// Timing
`define IOL_CLK_PERIOD_PS 5000
`define IOL_MS_PS 1000000000
`define IOL_MS_CYCLES (`IOL_MS_PS / `IOL_CLK_PERIOD_PS)
`define IOL_TENTH_MS 7'd100
`endif

// file: hw/iol_unit.v
// I/O line unit: line functions, sampling, sample queue, line passing and PWM outputs
`timescale 1ns/1ps
`default_nettype none
`include "iol_regs.vh"
module iol_unit #(
   parameter MS_CYCLES = `IOL_MS_CYCLES,
   parameter QDEPTH = 8,
   parameter QAW = 3
) (
   input wire sys_clk_in,
   input wire reset_in,
   input wire cmd_valid_in,
   input wire cmd_write_in,
   input wire [4:0] cmd_sel_in,
   input wire [63:0] cmd_data_in,
   output reg rsp_valid_out,
   output reg rsp_error_out,
   output reg [63:0] rsp_data_out,
   input wire [8:0] line_in,
   output reg [7:0] line_out,
   output reg [7:0] line_oe_out,
   input wire cts_level_in,
   input wire assoc_blink_in,
   output reg rts_level_out,
   input wire [59:0] adc_data_in,
   output reg adc_ref_internal_out,
   output reg smp_valid_out,
   input wire smp_ready_in,
   output reg [8:0] smp_dio_out,
   output reg [59:0] smp_adc_out,
   output reg [1:0] smp_kind_out,
   output reg smp_last_out,
   input wire rx_valid_in,
   input wire [63:0] rx_src_in,
   input wire [7:0] rx_dio_mask_in,
   input wire [7:0] rx_dio_in,
   input wire [1:0] rx_pwm_valid_in,
   input wire [19:0] rx_pwm_in,
   input wire [7:0] rx_rssi_in,
   output reg fwd_valid_out,
   output reg [63:0] fwd_src_out,
   output reg [7:0] fwd_dio_mask_out,
   output reg [7:0] fwd_dio_out,
   output reg [1:0] pwm_pin_out
);
   reg [2:0] func_r [0:8];
   reg fwd_en_r;
   reg [7:0] spt_r;
   reg [7:0] chg_mask_r;
   reg [15:0] interval_r;
   reg adc_ref_r;
   reg [63:0] bound_addr_r;
   reg [7:0] tmo_r [0:7];
   reg [1:0] pwm_func_r [0:1];
   reg [9:0] pwm_level_r [0:1];
   reg [7:0] pwm_hold_r;
   reg [7:0] rssi_dur_r;
   reg [8:0] sync1_r;
   reg [8:0] sync2_r;
   reg [8:0] prev_r;
   reg [31:0] ms_cnt_r;
   reg ms_tick_r;
   reg [6:0] tenth_cnt_r;
   reg tenth_tick_r;
   reg [15:0] ivl_cnt_r;
   reg [68:0] q_mem [0:QDEPTH-1];
   reg [QAW-1:0] q_wr_r;
   reg [QAW-1:0] q_rd_r;
   reg [QAW:0] q_cnt_r;
   reg drain_r;
   reg chg_pend_r;
   reg force_pend_r;
   reg [7:0] drv_r;
   reg [7:0] ltmr_r [0:7];
   reg [7:0] ptmr_r;
   reg [7:0] rtmr_r;
   reg [7:0] rssi_r;
   reg [9:0] pwm_cnt_r;
   integer i;

   // Legal function codes per line
   function fn_ok;
      input [3:0] line;
      input [63:0] code;
      begin
         if (code > 64'h5) begin
            fn_ok = 1'b0;
         end else if (line == 4'd8) begin
            fn_ok = (code == 64'h0) || (code == 64'h3);
         end else if (line == 4'd7 || line == 4'd6) begin
            fn_ok = (code != 64'h2);
         end else if (line == 4'd5) begin
            fn_ok = 1'b1;
         end else begin
            fn_ok = (code != 64'h1);
         end
      end
   endfunction

   wire [8:0] din_en;
   wire [5:0] adc_en;
   wire [7:0] out_en;
   wire [7:0] out_dflt;
   genvar g;
   generate
      for (g = 0; g < 9; g = g + 1) begin : g_en
         assign din_en[g] = (func_r[g] == `IOL_FN_DIN);
      end
      for (g = 0; g < 6; g = g + 1) begin : g_adc
         assign adc_en[g] = (func_r[g] == `IOL_FN_ADC);
      end
      for (g = 0; g < 8; g = g + 1) begin : g_out
         assign out_en[g] = (func_r[g] == `IOL_FN_OUT_LOW) || (func_r[g] == `IOL_FN_OUT_HIGH);
         assign out_dflt[g] = (func_r[g] == `IOL_FN_OUT_HIGH);
      end
   endgenerate

   wire any_in = (|din_en) || (|adc_en);
   wire [8:0] live_dio = sync2_r & din_en;
   wire [59:0] live_adc;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_adcm
         assign live_adc[g*10 +: 10] = adc_en[g] ? adc_data_in[g*10 +: 10] : 10'h000;
      end
   endgenerate
   // A change only counts on lines both masked and set as digital input
   wire chg_hit = |((sync2_r[7:0] ^ prev_r[7:0]) & chg_mask_r & din_en[7:0]);
   wire periodic = (interval_r != 16'h0000) && ms_tick_r && (ivl_cnt_r + 16'h0001 >= interval_r);
   wire q_full = (q_cnt_r == QDEPTH[QAW:0]);
   // Queue depth caps the usable group size
   wire [8:0] grp = ({1'b0, spt_r} > QDEPTH[8:0]) ? QDEPTH[8:0] : {1'b0, spt_r};
   wire push = periodic && any_in && !q_full;
   wire ld = !smp_valid_out || smp_ready_in;
   wire do_force = ld && force_pend_r;
   wire do_pop = ld && !force_pend_r && (q_cnt_r != 0) && (drain_r || chg_pend_r);
   wire do_chg = ld && !force_pend_r && chg_pend_r && (q_cnt_r == 0) && !do_pop;
   wire q_hit_grp = ({{(8-QAW){1'b0}}, q_cnt_r} + (push ? 9'd1 : 9'd0)) >= grp;
   wire rx_ok = rx_valid_in && (bound_addr_r != `IOL_RST_BOUND_ADDR) &&
                ((bound_addr_r == `IOL_ADDR_ANY) || (bound_addr_r == rx_src_in));
   wire is_wr = cmd_valid_in && cmd_write_in;

   // Host commands: configuration, force sample and output levels
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         for (i = 0; i < 9; i = i + 1) begin
            func_r[i] <= `IOL_FN_DISABLED;
         end
         func_r[5] <= `IOL_RST_FUNC_L5;
         func_r[7] <= `IOL_RST_FUNC_L7;
         fwd_en_r <= `IOL_RST_FWD_EN;
         spt_r <= `IOL_RST_SPT;
         chg_mask_r <= 8'h00;
         interval_r <= 16'h0000;
         adc_ref_r <= 1'b0;
         bound_addr_r <= `IOL_RST_BOUND_ADDR;
         for (i = 0; i < 8; i = i + 1) begin
            tmo_r[i] <= `IOL_RST_TMO;
         end
         pwm_func_r[0] <= `IOL_RST_PWM_PIN_0_FUNC;
         pwm_func_r[1] <= `IOL_RST_PWM_PIN_1_FUNC;
         pwm_hold_r <= `IOL_RST_PWM_HOLD;
         rssi_dur_r <= `IOL_RST_RSSI_DUR;
         rsp_valid_out <= 1'b0;
         rsp_error_out <= 1'b0;
         rsp_data_out <= 64'h0;
         force_pend_r <= 1'b0;
      end else begin
         rsp_valid_out <= cmd_valid_in;
         rsp_error_out <= 1'b0;
         rsp_data_out <= 64'h0;
         if (do_force) begin
            force_pend_r <= 1'b0;
         end
         if (cmd_valid_in) begin
            if (cmd_sel_in <= `IOL_SEL_FUNC_L8) begin
               rsp_data_out <= {61'h0, func_r[cmd_sel_in[3:0]]};
               if (cmd_write_in && fn_ok(cmd_sel_in[3:0], cmd_data_in)) begin
                  func_r[cmd_sel_in[3:0]] <= cmd_data_in[2:0];
               end else if (cmd_write_in) begin
                  rsp_error_out <= 1'b1;
               end
            end else if (cmd_sel_in == `IOL_SEL_FWD_EN) begin
               rsp_data_out <= {63'h0, fwd_en_r};
               if (is_wr && cmd_data_in <= 64'h1) fwd_en_r <= cmd_data_in[0];
               rsp_error_out <= cmd_write_in && (cmd_data_in > 64'h1);
            end else if (cmd_sel_in == `IOL_SEL_SPT) begin
               rsp_data_out <= {56'h0, spt_r};
               if (is_wr && cmd_data_in != 64'h0 && cmd_data_in <= 64'hFF) spt_r <= cmd_data_in[7:0];
               rsp_error_out <= cmd_write_in && (cmd_data_in == 64'h0 || cmd_data_in > 64'hFF);
            end else if (cmd_sel_in == `IOL_SEL_FORCE) begin
               if (any_in) begin
                  force_pend_r <= 1'b1;
               end else begin
                  rsp_error_out <= 1'b1;
               end
            end else if (cmd_sel_in == `IOL_SEL_OUT_LEVEL) begin
               rsp_data_out <= {56'h0, drv_r};
            end else if (cmd_sel_in == `IOL_SEL_CHG_MASK) begin
               rsp_data_out <= {56'h0, chg_mask_r};
               if (is_wr) chg_mask_r <= cmd_data_in[7:0];
            end else if (cmd_sel_in == `IOL_SEL_INTERVAL) begin
               rsp_data_out <= {48'h0, interval_r};
               if (is_wr) interval_r <= cmd_data_in[15:0];
            end else if (cmd_sel_in == `IOL_SEL_ADC_REF) begin
               rsp_data_out <= {63'h0, adc_ref_r};
               if (is_wr && cmd_data_in <= 64'h1) adc_ref_r <= cmd_data_in[0];
               rsp_error_out <= cmd_write_in && (cmd_data_in > 64'h1);
            end else if (cmd_sel_in == `IOL_SEL_BOUND_ADDR) begin
               rsp_data_out <= bound_addr_r;
               if (is_wr) bound_addr_r <= cmd_data_in;
            end else if (cmd_sel_in >= `IOL_SEL_TMO_L0 && cmd_sel_in <= `IOL_SEL_TMO_L7) begin
               rsp_data_out <= {56'h0, tmo_r[cmd_sel_in[2:0] - 3'd1]};
               if (is_wr) tmo_r[cmd_sel_in[2:0] - 3'd1] <= cmd_data_in[7:0];
            end else if (cmd_sel_in == `IOL_SEL_PWM_PIN_0_FUNC || cmd_sel_in == `IOL_SEL_PWM_PIN_1_FUNC) begin
               rsp_data_out <= {62'h0, pwm_func_r[cmd_sel_in[1]]};
               if (is_wr && cmd_data_in <= 64'h2) pwm_func_r[cmd_sel_in[1]] <= cmd_data_in[1:0];
               rsp_error_out <= cmd_write_in && (cmd_data_in > 64'h2);
            end else if (cmd_sel_in == `IOL_SEL_PWM_PIN_0_LEVEL || cmd_sel_in == `IOL_SEL_PWM_PIN_1_LEVEL) begin
               rsp_data_out <= {54'h0, pwm_level_r[~cmd_sel_in[0]]};
               rsp_error_out <= cmd_write_in && (cmd_data_in > 64'h3FF);
            end else if (cmd_sel_in == `IOL_SEL_PWM_HOLD) begin
               rsp_data_out <= {56'h0, pwm_hold_r};
               if (is_wr) pwm_hold_r <= cmd_data_in[7:0];
            end else if (cmd_sel_in == `IOL_SEL_RSSI_DUR) begin
               rsp_data_out <= {56'h0, rssi_dur_r};
               if (is_wr) rssi_dur_r <= cmd_data_in[7:0];
            end else begin
               rsp_error_out <= 1'b1;
            end
         end
      end
   end

   // Pin synchroniser and timebase
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         sync1_r <= 9'h000;
         sync2_r <= 9'h000;
         prev_r <= 9'h000;
         ms_cnt_r <= 32'h0;
         ms_tick_r <= 1'b0;
         tenth_cnt_r <= 7'h00;
         tenth_tick_r <= 1'b0;
         ivl_cnt_r <= 16'h0000;
      end else begin
         sync1_r <= line_in;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
         ms_tick_r <= (ms_cnt_r == MS_CYCLES - 1);
         ms_cnt_r <= (ms_cnt_r == MS_CYCLES - 1) ? 32'h0 : ms_cnt_r + 32'h1;
         tenth_tick_r <= 1'b0;
         if (ms_tick_r) begin
            tenth_tick_r <= (tenth_cnt_r == `IOL_TENTH_MS - 7'd1);
            tenth_cnt_r <= (tenth_cnt_r == `IOL_TENTH_MS - 7'd1) ? 7'h00 : tenth_cnt_r + 7'd1;
         end
         if (interval_r == 16'h0000 || periodic) begin
            ivl_cnt_r <= 16'h0000;
         end else if (ms_tick_r) begin
            ivl_cnt_r <= ivl_cnt_r + 16'h0001;
         end
      end
   end

   // Sample queue and sample stream; forced samples jump the queue
   always @(posedge sys_clk_in) begin
      if (push) begin
         q_mem[q_wr_r] <= {live_dio, live_adc};
      end
   end

   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         q_wr_r <= {QAW{1'b0}};
         q_rd_r <= {QAW{1'b0}};
         q_cnt_r <= {(QAW+1){1'b0}};
         drain_r <= 1'b0;
         chg_pend_r <= 1'b0;
         smp_valid_out <= 1'b0;
         smp_dio_out <= 9'h000;
         smp_adc_out <= 60'h0;
         smp_kind_out <= `IOL_KIND_PERIODIC;
         smp_last_out <= 1'b0;
      end else begin
         if (push) q_wr_r <= q_wr_r + 1'b1;
         if (do_pop) q_rd_r <= q_rd_r + 1'b1;
         q_cnt_r <= q_cnt_r + (push ? 1'b1 : 1'b0) - (do_pop ? 1'b1 : 1'b0);
         if (push && q_hit_grp) begin
            drain_r <= 1'b1;
         end else if (do_pop && q_cnt_r == 1) begin
            drain_r <= 1'b0;
         end
         // A change arriving in the same cycle the flag clears is kept
         if (chg_hit) begin
            chg_pend_r <= 1'b1;
         end else if (do_chg) begin
            chg_pend_r <= 1'b0;
         end
         if (ld) smp_valid_out <= 1'b0;
         if (do_force) begin
            smp_valid_out <= 1'b1;
            smp_dio_out <= live_dio;
            smp_adc_out <= live_adc;
            smp_kind_out <= `IOL_KIND_FORCED;
            smp_last_out <= 1'b1;
         end else if (do_pop) begin
            smp_valid_out <= 1'b1;
            {smp_dio_out, smp_adc_out} <= q_mem[q_rd_r];
            smp_kind_out <= `IOL_KIND_PERIODIC;
            smp_last_out <= (q_cnt_r == 1);
         end else if (do_chg) begin
            smp_valid_out <= 1'b1;
            smp_dio_out <= live_dio;
            smp_adc_out <= 60'h0;
            smp_kind_out <= `IOL_KIND_CHANGE;
            smp_last_out <= 1'b1;
         end
      end
   end

   // Output lines, passing with per-line timeouts, forwarding
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         drv_r <= 8'h00;
         line_out <= 8'h00;
         line_oe_out <= 8'h00;
         rts_level_out <= 1'b0;
         adc_ref_internal_out <= 1'b0;
         fwd_valid_out <= 1'b0;
         fwd_src_out <= 64'h0;
         fwd_dio_mask_out <= 8'h00;
         fwd_dio_out <= 8'h00;
         for (i = 0; i < 8; i = i + 1) begin
            ltmr_r[i] <= 8'h00;
         end
      end else begin
         adc_ref_internal_out <= adc_ref_r;
         rts_level_out <= (func_r[6] == `IOL_FN_SPECIAL) ? sync2_r[6] : 1'b0;
         fwd_valid_out <= rx_valid_in && fwd_en_r;
         if (rx_valid_in) begin
            fwd_src_out <= rx_src_in;
            fwd_dio_mask_out <= rx_dio_mask_in;
            fwd_dio_out <= rx_dio_in;
         end
         for (i = 0; i < 8; i = i + 1) begin
            if (!out_en[i]) begin
               drv_r[i] <= out_dflt[i];
               ltmr_r[i] <= 8'h00;
            end else if (rx_ok && rx_dio_mask_in[i]) begin
               drv_r[i] <= rx_dio_in[i];
               ltmr_r[i] <= (rx_dio_in[i] != out_dflt[i]) ? tmo_r[i] : 8'h00;
            end else if (rx_ok && ltmr_r[i] != 8'h00) begin
               ltmr_r[i] <= tmo_r[i];
            end else if (is_wr && cmd_sel_in == `IOL_SEL_OUT_LEVEL) begin
               drv_r[i] <= cmd_data_in[i];
            end else if (tenth_tick_r && ltmr_r[i] != 8'h00) begin
               ltmr_r[i] <= ltmr_r[i] - 8'd1;
               if (ltmr_r[i] == 8'd1) drv_r[i] <= out_dflt[i];
            end
            line_oe_out[i] <= out_en[i];
            line_out[i] <= drv_r[i];
         end
         // Special functions drive lines 5 and 7 as outputs
         if (func_r[7] == `IOL_FN_SPECIAL) begin
            line_oe_out[7] <= 1'b1;
            line_out[7] <= cts_level_in;
         end
         if (func_r[5] == `IOL_FN_SPECIAL) begin
            line_oe_out[5] <= 1'b1;
            line_out[5] <= assoc_blink_in;
         end
      end
   end

   // PWM levels, shared hold timer and signal strength timer
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         pwm_level_r[0] <= 10'h000;
         pwm_level_r[1] <= 10'h000;
         ptmr_r <= 8'h00;
         rtmr_r <= 8'h00;
         rssi_r <= 8'h00;
         pwm_cnt_r <= 10'h000;
         pwm_pin_out <= 2'b00;
      end else begin
         pwm_cnt_r <= pwm_cnt_r + 10'd1;
         if (rx_valid_in) begin
            rssi_r <= rx_rssi_in;
            rtmr_r <= rssi_dur_r;
         end else if (tenth_tick_r && rtmr_r != 8'h00) begin
            rtmr_r <= rtmr_r - 8'd1;
         end
         if (rx_ok && (rx_pwm_valid_in != 2'b00) && (rx_pwm_in != 20'h0)) begin
            ptmr_r <= pwm_hold_r;
         end else if (rx_ok && ptmr_r != 8'h00) begin
            ptmr_r <= pwm_hold_r;
         end else if (tenth_tick_r && ptmr_r != 8'h00) begin
            ptmr_r <= ptmr_r - 8'd1;
         end
         for (i = 0; i < 2; i = i + 1) begin
            if (rx_ok && rx_pwm_valid_in[i]) begin
               pwm_level_r[i] <= rx_pwm_in[i*10 +: 10];
            end else if (is_wr && cmd_data_in <= 64'h3FF &&
                         cmd_sel_in == (i == 0 ? `IOL_SEL_PWM_PIN_0_LEVEL : `IOL_SEL_PWM_PIN_1_LEVEL)) begin
               pwm_level_r[i] <= cmd_data_in[9:0];
            end else if (tenth_tick_r && ptmr_r == 8'd1) begin
               pwm_level_r[i] <= 10'h000;
            end
            if (pwm_func_r[i] == `IOL_PWM_LEVEL) begin
               pwm_pin_out[i] <= (pwm_cnt_r < pwm_level_r[i]);
            end else if (pwm_func_r[i] == `IOL_PWM_RSSI) begin
               pwm_pin_out[i] <= (rtmr_r != 8'h00) && (pwm_cnt_r < {rssi_r, 2'b00});
            end else begin
               pwm_pin_out[i] <= 1'b0;
            end
         end
      end
   end
endmodule // iol_unit
`default_nettype wire

// file: test/iol_unit_asserts.sv
// Port checker for the I/O line unit
`timescale 1ns/1ps
`default_nettype none
module iol_unit_asserts (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic cmd_valid_in,
   input wire logic cmd_write_in,
   input wire logic [4:0] cmd_sel_in,
   input wire logic [63:0] cmd_data_in,
   input wire logic rsp_valid_out,
   input wire logic rsp_error_out,
   input wire logic rx_valid_in,
   input wire logic fwd_valid_out,
   input wire logic smp_valid_out,
   input wire logic smp_ready_in,
   input wire logic [59:0] smp_adc_out,
   input wire logic [1:0] smp_kind_out,
   input wire logic smp_last_out
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (reset_in);
   sequence s_wr(ok);
      cmd_valid_in && cmd_write_in && ok;
   endsequence
   sequence s_refused;
      rsp_valid_out && rsp_error_out;
   endsequence
   sequence s_stall;
      smp_valid_out && !smp_ready_in;
   endsequence
   a_rsp_timing: assert property (
      cmd_valid_in |=> rsp_valid_out) else $error("command not answered");
   a_line8_codes: assert property (
      s_wr(cmd_sel_in == 5'h08 && cmd_data_in != 64'h0 && cmd_data_in != 64'h3) |=> s_refused)
      else $error("line 8 code taken");
   a_flow_code2: assert property (
      s_wr((cmd_sel_in == 5'h06 || cmd_sel_in == 5'h07) && cmd_data_in == 64'h2) |=> s_refused)
      else $error("flow line code 2 taken");
   a_low_code1: assert property (
      s_wr(cmd_sel_in < 5'h05 && cmd_data_in == 64'h1) |=> s_refused) else $error("low line code 1 taken");
   a_count_range: assert property (
      s_wr(cmd_sel_in == 5'h0A && (cmd_data_in == 64'h0 || cmd_data_in > 64'hFF)) |=> s_refused)
      else $error("bad sample count taken");
   a_ref_range: assert property (
      s_wr(cmd_sel_in == 5'h0F && cmd_data_in > 64'h1) |=> s_refused) else $error("bad reference taken");
   a_pwm_range: assert property (
      s_wr((cmd_sel_in == 5'h1B || cmd_sel_in == 5'h1C) && cmd_data_in > 64'h3FF) |=> s_refused)
      else $error("pwm level over range taken");
   a_smp_held: assert property (
      s_stall |=> smp_valid_out && $stable(smp_kind_out) && $stable(smp_adc_out)) else $error("sample dropped");
   a_change_digital: assert property (
      smp_valid_out && smp_kind_out == 2'h2 |-> smp_adc_out == 60'h0) else $error("change sample has analog");
   a_forced_alone: assert property (
      smp_valid_out && smp_kind_out == 2'h1 |-> smp_last_out) else $error("forced sample not last");
   a_fwd_cause: assert property (
      fwd_valid_out |-> $past(rx_valid_in)) else $error("forward without packet");
endmodule // iol_unit_asserts
bind iol_unit iol_unit_asserts u_chk (.sys_clk_in, .reset_in, .cmd_valid_in, .cmd_write_in, .cmd_sel_in,
   .cmd_data_in, .rsp_valid_out, .rsp_error_out, .rx_valid_in, .fwd_valid_out, .smp_valid_out,
   .smp_ready_in, .smp_adc_out, .smp_kind_out, .smp_last_out);
`default_nettype wire

// file: test/iol_host_sink.sv
// Host-side sample consumer model
`timescale 1ns/1ps
`default_nettype none
module iol_host_sink (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic smp_valid_in,
   input wire logic [8:0] smp_dio_in,
   input wire logic [1:0] smp_kind_in,
   input wire logic smp_last_in,
   output logic smp_ready_out,
   output logic [7:0] got_n_out,
   output logic [8:0] got_dio_out,
   output logic [1:0] got_kind_out,
   output logic got_last_out
);
   logic [1:0] cyc_r;
   // Stalls half the time, so held samples must stay put
   assign smp_ready_out = cyc_r[1];
   always @(posedge sys_clk_in) begin
      cyc_r <= reset_in ? 2'h0 : cyc_r + 2'h1;
      if (reset_in) begin
         got_n_out <= 8'h00;
      end else if (smp_valid_in && smp_ready_out) begin
         got_n_out <= got_n_out + 8'h01;
         got_dio_out <= smp_dio_in;
         got_kind_out <= smp_kind_in;
         got_last_out <= smp_last_in;
      end
   end
endmodule // iol_host_sink
`default_nettype wire

// file: test/tb_iol_unit.sv
// Self-checking bench for the I/O line unit
`timescale 1ns/1ps
`default_nettype none
module tb_iol_unit;
   logic sys_clk_in, reset_in, cmd_valid_in, cmd_write_in, rx_valid_in, cts_level_in, assoc_blink_in;
   logic rsp_valid_out, rsp_error_out, rts_level_out, adc_ref_internal_out, smp_valid_out, smp_ready_in;
   logic smp_last_out, fwd_valid_out, got_last, got_e;
   logic [1:0] rx_pwm_valid_in, smp_kind_out, pwm_pin_out, got_kind;
   logic [4:0] cmd_sel_in;
   logic [7:0] line_out, line_oe_out, rx_dio_mask_in, rx_dio_in, rx_rssi_in, fwd_dio_mask_out, fwd_dio_out, got_n, n;
   logic [8:0] line_in, smp_dio_out, got_dio;
   logic [19:0] rx_pwm_in;
   logic [59:0] adc_data_in, smp_adc_out;
   logic [63:0] cmd_data_in, rx_src_in, rsp_data_out, fwd_src_out, got_d;
   logic [31:0] rng;
   int err_count = 0;
   int n_checks = 0;
   int cycles = 0;
   logic [4:0] rs [16] = '{5'h00, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11,
      5'h19, 5'h1A, 5'h1D, 5'h1E};
   logic [63:0] rv [16] = '{64'h0, 64'h1, 64'h0, 64'h1, 64'h0, 64'h1, 64'h1, 64'h0, 64'h0, 64'h0,
      64'hFFFFFFFFFFFFFFFF, 64'hFF, 64'h1, 64'h0, 64'hFF, 64'h28};
   iol_unit #(.MS_CYCLES(20)) uut (.sys_clk_in, .reset_in, .cmd_valid_in, .cmd_write_in, .cmd_sel_in,
      .cmd_data_in, .rsp_valid_out, .rsp_error_out, .rsp_data_out, .line_in, .line_out, .line_oe_out,
      .cts_level_in, .assoc_blink_in, .rts_level_out, .adc_data_in, .adc_ref_internal_out, .smp_valid_out,
      .smp_ready_in, .smp_dio_out, .smp_adc_out, .smp_kind_out, .smp_last_out, .rx_valid_in, .rx_src_in,
      .rx_dio_mask_in, .rx_dio_in, .rx_pwm_valid_in, .rx_pwm_in, .rx_rssi_in, .fwd_valid_out, .fwd_src_out,
      .fwd_dio_mask_out, .fwd_dio_out, .pwm_pin_out);
   iol_host_sink sink (.sys_clk_in, .reset_in, .smp_valid_in(smp_valid_out), .smp_dio_in(smp_dio_out),
      .smp_kind_in(smp_kind_out), .smp_last_in(smp_last_out), .smp_ready_out(smp_ready_in),
      .got_n_out(got_n), .got_dio_out(got_dio), .got_kind_out(got_kind), .got_last_out(got_last));
   initial begin
      sys_clk_in = 1'b0;
      forever #2.5 sys_clk_in = ~sys_clk_in;
   end
   function automatic logic legal(input int sel, input int code);
      case (sel)
         8: return code == 0 || code == 3;
         7, 6: return code != 2 && code <= 5;
         5: return code <= 5;
         default: return code != 1 && code <= 5;
      endcase
   endfunction
   task automatic rnd;
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      n_checks = n_checks + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic cmd(input logic wr, input logic [4:0] sel, input logic [63:0] data);
      @(posedge sys_clk_in);
      #1;
      cmd_valid_in = 1'b1;
      cmd_write_in = wr;
      cmd_sel_in = sel;
      cmd_data_in = data;
      @(posedge sys_clk_in);
      #1;
      cmd_valid_in = 1'b0;
      got_e = rsp_error_out;
      got_d = rsp_data_out;
   endtask
   task automatic rx(input logic [63:0] src, input logic pass);
      @(posedge sys_clk_in);
      #1;
      rx_valid_in = 1'b1;
      rx_src_in = src;
      @(posedge sys_clk_in);
      #1;
      rx_valid_in = 1'b0;
      chk("fwd src", src, fwd_valid_out ? fwd_src_out : 64'h0);
      @(posedge sys_clk_in);
      #1;
      chk("passed level", pass, line_out[1]);
   endtask
   task automatic wait_got(input logic [7:0] k);
      for (int t = 0; t < 300 && got_n == k; t++) @(posedge sys_clk_in) #1;
   endtask
   always @(posedge sys_clk_in) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         err_count = err_count + 1;
         results();
      end
   end
   initial begin
      rng = 32'h67AAA50F;
      {cmd_valid_in, cmd_write_in, cmd_sel_in, cmd_data_in, rx_valid_in, rx_src_in, rx_pwm_valid_in, rx_pwm_in} = '0;
      rx_dio_mask_in = 8'h02;
      rx_dio_in = 8'h02;
      rnd();
      {cts_level_in, assoc_blink_in, line_in, rx_rssi_in} = rng[18:0];
      adc_data_in = {rng, rng[27:0]};
      reset_in = 1'b1;
      repeat (6) @(posedge sys_clk_in);
      #1;
      reset_in = 1'b0;
      for (int i = 0; i < 16; i++) begin
         cmd(1'b0, rs[i], 64'h0);
         chk("reset value", rv[i], got_d);
      end
      $display("reset values done");
      for (int i = 0; i < 9; i++) begin
         for (int j = 0; j < 7; j++) begin
            cmd(1'b1, i[4:0], j);
            chk("code refused", !legal(i, j), got_e);
         end
         cmd(1'b1, i[4:0], 64'h0);
      end
      $display("function codes done");
      cmd(1'b1, 5'h0B, 64'h0);
      chk("empty force", 64'h1, got_e);
      cmd(1'b1, 5'h00, 64'h3);
      cmd(1'b1, 5'h08, 64'h3);
      rnd();
      line_in = rng[8:0];
      repeat (4) @(posedge sys_clk_in);
      n = got_n;
      cmd(1'b1, 5'h0B, 64'h0);
      chk("force error", 64'h0, got_e);
      wait_got(n);
      chk("force kind", 64'h1, got_kind);
      chk("force dio", {line_in[8], 7'h0, line_in[0]}, got_dio);
      $display("forced sample done");
      cmd(1'b1, 5'h0A, 64'h2);
      n = got_n;
      cmd(1'b1, 5'h0E, 64'h1);
      wait_got(n);
      chk("periodic kind", 64'h0, got_kind);
      chk("group first", 64'h0, got_last);
      wait_got(n + 8'h01);
      chk("group last", 64'h1, got_last);
      // Third tick stays queued, short of a group
      repeat (30) @(posedge sys_clk_in);
      cmd(1'b1, 5'h0E, 64'h0);
      n = got_n;
      repeat (100) @(posedge sys_clk_in);
      chk("periodic off", n, got_n);
      cmd(1'b1, 5'h0D, 64'h1);
      line_in[0] = ~line_in[0];
      wait_got(n);
      chk("queued first", 64'h0, got_kind);
      wait_got(n + 8'h01);
      chk("change kind", 64'h2, got_kind);
      chk("change dio", {line_in[8], 7'h0, line_in[0]}, got_dio);
      $display("sampling done");
      cmd(1'b1, 5'h01, 64'h4);
      cmd(1'b1, 5'h12, 64'h2);
      rnd();
      rx({rng, rng}, 1'b0);
      cmd(1'b1, 5'h10, 64'hFFFF);
      rx({rng, rng}, 1'b1);
      repeat (1900) @(posedge sys_clk_in);
      chk("held level", 64'h1, line_out[1]);
      repeat (2200) @(posedge sys_clk_in);
      chk("timed out", 64'h0, line_out[1]);
      cmd(1'b1, 5'h0C, 64'h2);
      repeat (2) @(posedge sys_clk_in) #1;
      chk("level cmd", 64'h3, {line_oe_out[1], line_out[1]});
      $display("line passing done");
      cmd(1'b1, 5'h0F, 64'h1);
      @(posedge sys_clk_in) #1;
      chk("internal ref", 64'h1, adc_ref_internal_out);
      cmd(1'b1, 5'h1C, 64'h3FF);
      chk("level max", 64'h0, got_e);
      cmd(1'b1, 5'h1C, 64'h400);
      chk("level over", 64'h1, got_e);
      cmd(1'b1, 5'h1A, 64'h3);
      chk("pwm code", 64'h1, got_e);
      $display("settings done");
      results();
   end
endmodule // tb_iol_unit
`default_nettype wire
